// ### hw/flash_reg_pkg.sv
// Constants for the serial flash register access command block
package flash_reg_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_STATUS1_READ = 8'h05;
  localparam logic [7:0] OP_STATUS2_READ = 8'h07;
  localparam logic [7:0] OP_CONFIG_READ = 8'h35;
  localparam logic [7:0] OP_REG_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  // ==========================================================
  // Field positions
  localparam int SR1_WIP = 0;
  localparam int SR1_WEL = 1;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_BP_HI = 4;
  localparam int SR1_EERR = 5;
  localparam int SR1_PERR = 6;
  localparam int SR1_STATUS_WRITE_DISABLE = 7;
  localparam int CR1_QUAD = 1;
  localparam int CR1_BPNV = 3;
  localparam int CR2_QPI = 6;
  // ==========================================================
  // Reset values
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] CR1_RESET = 8'h00;
  localparam logic [7:0] CR2_RESET = 8'h00;
  // ==========================================================
  // Counts
  localparam logic [4:0] BITS_BYTE = 5'h08;
  localparam logic [4:0] BITS_WORD = 5'h10;
  localparam logic [4:0] NIB_BYTE = 5'h02;
  localparam logic [4:0] NIB_WORD = 5'h04;
  localparam int CLK_MHZ = 25;
  localparam int WRITE_TIME_US = 20;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;
endpackage : flash_reg_pkg

// ### hw/flash_sync2.sv
// Two flip-flop synchroniser for one level
module flash_sync2 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  logic meta_next;
  logic q_next;

  always_comb begin
    meta_next = i_d;
    q_next = meta_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      o_q <= q_next;
    end
  end
endmodule : flash_sync2

// ### hw/flash_write_timer.sv
// Self-timed register write engine with completion pulse
module flash_write_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [flash_reg_pkg::CNT_W-1:0] i_cycles,
  output logic o_busy,
  output logic o_done
);
  logic [flash_reg_pkg::CNT_W-1:0] cnt_reg;
  logic [flash_reg_pkg::CNT_W-1:0] cnt_next;
  logic busy_next;
  logic done_next;

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = o_busy;
    done_next = 1'b0;
    if (i_start && !o_busy) begin
      cnt_next = i_cycles;
      busy_next = 1'b1;
    end else if (o_busy) begin
      if (cnt_reg <= {{(flash_reg_pkg::CNT_W-1){1'b0}}, 1'b1}) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - {{(flash_reg_pkg::CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_busy <= busy_next;
      o_done <= done_next;
    end
  end
endmodule : flash_write_timer

// ### hw/flash_reg_cmd.sv
// Serial flash status and configuration register command interpreter
// ==========================================================
// Overview of operation
// - Opcode 05h shifts out status register one
// - Repeat register each byte (eight clocks serial, two in quad-all), refreshed
// - Opcode 07h shifts out status register two, ignored in quad-all
// - Opcode 35h shifts out configuration register one, ignored in quad-all
// - Quad-all: status1 read uses four lines
// - Register write needs write-enable latch set
// - Write after 8 or 16 bits only
// - Self-timed write sets busy, clears latch
// - Erase/program failure sets error flags
// - Protect target select routes block bits
// - Disable bit clear: latch alone permits
// - Disable bit and pin low reject silently
// - Protection regardless of order, pin releases
// - Quad mode disables pin protection
// - Status registers reset to zero
// - Opcode 06h sets latch, exact eight bits
// - Opcode 04h clears latch unless busy
// - Busy flag held in status bit zero
// - Config2 bit six selects quad-all mode
module flash_reg_cmd (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic [3:0] i_io,
  input wire logic i_wp_n,
  input wire logic i_op_fail_erase,
  input wire logic i_op_fail_prog,
  input wire logic i_ext_busy,
  input wire logic [7:0] i_status2,
  input wire logic i_quad_all_set,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  output logic [7:0] o_volatile_status1,
  output logic [7:0] o_nonvolatile_status1,
  output logic [7:0] o_volatile_config1,
  output logic [7:0] o_nonvolatile_config1,
  output logic o_write_rejected
);
  // ==========================================================
  // Reset and pin synchronisers
  logic rst_reg;
  logic sel;
  logic sck_s;
  logic wp_n_s;
  logic [3:0] io_s;

  flash_sync2 u_sync_rst (.i_clk(i_clk), .i_rst_n(i_arst_n), .i_d(1'b1), .o_q(rst_reg));
  // Select inverted ahead of the flops so reset level equals idle level
  flash_sync2 u_sync_cs (.i_clk(i_clk), .i_rst_n(rst_reg), .i_d(~i_cs_n), .o_q(sel));
  flash_sync2 u_sync_sck (.i_clk(i_clk), .i_rst_n(rst_reg), .i_d(i_sck), .o_q(sck_s));
  flash_sync2 u_sync_wp (.i_clk(i_clk), .i_rst_n(rst_reg), .i_d(i_wp_n), .o_q(wp_n_s));
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_io
    flash_sync2 u_sync_io (.i_clk(i_clk), .i_rst_n(rst_reg), .i_d(i_io[gi]), .o_q(io_s[gi]));
  end

  logic sck_d_reg, sel_d_reg;
  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = sel && sck_s && !sck_d_reg;
  assign sck_fall = sel && !sck_s && sck_d_reg;
  assign cs_rise = !sel && sel_d_reg;

  always_ff @(posedge i_clk or negedge rst_reg) begin
    if (!rst_reg) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel;
    end
  end

  // ==========================================================
  // Command state machine
  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_DATA = 2'b01,
    ST_READ = 2'b11,
    ST_IGNORE = 2'b10
  } cmd_state_e;

  cmd_state_e state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] op_reg, op_next;
  logic [15:0] data_reg, data_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] io_reg, io_next;
  logic [3:0] oe_reg, oe_next;
  logic quad_all;
  logic wr_start;
  logic wr_busy;
  logic wr_done;
  logic [7:0] volatile_status1_reg, volatile_status1_next;
  logic [7:0] nonvolatile_status1_reg, nonvolatile_status1_next;
  logic [7:0] volatile_config1_reg, volatile_config1_next;
  logic [7:0] nonvolatile_config1_reg, nonvolatile_config1_next;
  logic [7:0] volatile_config2_reg, volatile_config2_next;
  logic [15:0] pend_reg, pend_next;
  logic pend_wide_reg, pend_wide_next;
  logic rej_reg, rej_next;
  logic hw_protected;
  logic [7:0] rd_byte;

  assign quad_all = volatile_config2_reg[flash_reg_pkg::CR2_QPI];
  // pin protection, level based so order is irrelevant
  assign hw_protected = volatile_status1_reg[flash_reg_pkg::SR1_STATUS_WRITE_DISABLE] && !wp_n_s
                        && !volatile_config1_reg[flash_reg_pkg::CR1_QUAD];

  function automatic logic [4:0] unit_len(input logic qa, input logic wide);
    if (qa) unit_len = wide ? flash_reg_pkg::NIB_WORD : flash_reg_pkg::NIB_BYTE;
    else unit_len = wide ? flash_reg_pkg::BITS_WORD : flash_reg_pkg::BITS_BYTE;
  endfunction : unit_len

  // ==========================================================
  // Read data select
  always_comb begin
    case (op_reg)
      flash_reg_pkg::OP_STATUS1_READ: rd_byte = volatile_status1_reg;
      flash_reg_pkg::OP_STATUS2_READ: rd_byte = i_status2;
      flash_reg_pkg::OP_CONFIG_READ: rd_byte = volatile_config1_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    data_next = data_reg;
    shift_next = shift_reg;
    io_next = io_reg;
    oe_next = oe_reg;
    wr_start = 1'b0;
    if (!sel) begin
      state_next = ST_OPCODE;
      cnt_next = 5'h00;
      oe_next = 4'h0;
    end else begin
      case (state_reg)
        ST_OPCODE: begin
          if (sck_rise) begin
            // MSB first, one or four bits a rise
            op_next = quad_all ? {op_reg[3:0], io_s} : {op_reg[6:0], io_s[0]};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg + 5'h01 == unit_len(quad_all, 1'b0)) begin
              cnt_next = 5'h00;
              state_next = ST_DATA;
              case (op_next)
                flash_reg_pkg::OP_STATUS1_READ: state_next = ST_READ;
                flash_reg_pkg::OP_STATUS2_READ,
                flash_reg_pkg::OP_CONFIG_READ: begin
                  state_next = quad_all ? ST_IGNORE : ST_READ;
                end
                flash_reg_pkg::OP_REG_WRITE,
                flash_reg_pkg::OP_WRITE_ENABLE,
                flash_reg_pkg::OP_WRITE_DISABLE: state_next = ST_DATA;
                default: state_next = ST_IGNORE;
              endcase
            end
          end
        end
        ST_DATA: begin
          if (sck_rise) begin
            data_next = quad_all ? {data_reg[11:0], io_s} : {data_reg[14:0], io_s[0]};
            if (cnt_reg != 5'h1f) cnt_next = cnt_reg + 5'h01;
          end
        end
        ST_READ: begin
          if (sck_fall) begin
            if (cnt_reg == 5'h00) begin
              shift_next = quad_all ? {rd_byte[3:0], 4'h0} : {rd_byte[6:0], 1'b0};
              io_next = quad_all ? rd_byte[7:4] : {2'b00, rd_byte[7], 1'b0};
            end else begin
              shift_next = quad_all ? {shift_reg[3:0], 4'h0} : {shift_reg[6:0], 1'b0};
              io_next = quad_all ? shift_reg[7:4] : {2'b00, shift_reg[7], 1'b0};
            end
            oe_next = quad_all ? 4'hf : 4'h2;
            cnt_next = (cnt_reg + 5'h01 == unit_len(quad_all, 1'b0)) ? 5'h00 : cnt_reg + 5'h01;
          end
        end
        default: begin
        end
      endcase
    end
    if (cs_rise) begin
      oe_next = 4'h0;
      if (state_reg == ST_DATA && op_reg == flash_reg_pkg::OP_REG_WRITE && !wr_busy
          && volatile_status1_reg[flash_reg_pkg::SR1_WEL] && !hw_protected
          && (cnt_reg == unit_len(quad_all, 1'b0) || cnt_reg == unit_len(quad_all, 1'b1)))
        wr_start = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_reg) begin
    if (!rst_reg) begin
      state_reg <= ST_OPCODE;
      cnt_reg <= 5'h00;
      op_reg <= 8'h00;
      data_reg <= 16'h0000;
      shift_reg <= 8'h00;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      data_reg <= data_next;
      shift_reg <= shift_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
    end
  end

  // ==========================================================
  // Self-timed write
  // start at select release
  flash_write_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(rst_reg),
    .i_start(wr_start),
    .i_cycles(flash_reg_pkg::CNT_W'(flash_reg_pkg::WRITE_CYCLES)),
    .o_busy(wr_busy),
    .o_done(wr_done)
  );

  // ==========================================================
  // Register state
  logic cmd_end_byte;
  assign cmd_end_byte = cs_rise && state_reg == ST_DATA && cnt_reg == 5'h00;

  always_comb begin
    volatile_status1_next = volatile_status1_reg;
    nonvolatile_status1_next = nonvolatile_status1_reg;
    volatile_config1_next = volatile_config1_reg;
    nonvolatile_config1_next = nonvolatile_config1_reg;
    volatile_config2_next = volatile_config2_reg;
    pend_next = pend_reg;
    pend_wide_next = pend_wide_reg;
    rej_next = 1'b0;
    volatile_status1_next[flash_reg_pkg::SR1_WIP] = wr_busy || i_ext_busy;
    if (i_quad_all_set) volatile_config2_next[flash_reg_pkg::CR2_QPI] = 1'b1;
    if (cmd_end_byte && op_reg == flash_reg_pkg::OP_WRITE_ENABLE)
      volatile_status1_next[flash_reg_pkg::SR1_WEL] = 1'b1;
    if (cmd_end_byte && op_reg == flash_reg_pkg::OP_WRITE_DISABLE
        && !volatile_status1_reg[flash_reg_pkg::SR1_WIP])
      volatile_status1_next[flash_reg_pkg::SR1_WEL] = 1'b0;
    if (wr_start) begin
      pend_wide_next = cnt_reg == unit_len(quad_all, 1'b1);
      pend_next = pend_wide_next ? data_reg : {data_reg[7:0], 8'h00};
    end
    // silent reject indication only on this port
    if (cs_rise && state_reg == ST_DATA && op_reg == flash_reg_pkg::OP_REG_WRITE
        && hw_protected)
      rej_next = 1'b1;
    if (wr_done) begin
      if (i_op_fail_erase || i_op_fail_prog) begin
        volatile_status1_next[flash_reg_pkg::SR1_EERR] = i_op_fail_erase;
        volatile_status1_next[flash_reg_pkg::SR1_PERR] = i_op_fail_prog;
      end else begin
        volatile_status1_next[flash_reg_pkg::SR1_STATUS_WRITE_DISABLE] = pend_reg[15];
        nonvolatile_status1_next[flash_reg_pkg::SR1_STATUS_WRITE_DISABLE] = pend_reg[15];
        if (nonvolatile_config1_reg[flash_reg_pkg::CR1_BPNV])
          volatile_status1_next[flash_reg_pkg::SR1_BP_HI:flash_reg_pkg::SR1_BP_LO] = pend_reg[12:10];
        else begin
          nonvolatile_status1_next[flash_reg_pkg::SR1_BP_HI:flash_reg_pkg::SR1_BP_LO] = pend_reg[12:10];
          volatile_status1_next[flash_reg_pkg::SR1_BP_HI:flash_reg_pkg::SR1_BP_LO] = pend_reg[12:10];
        end
        if (pend_wide_reg) begin
          volatile_config1_next = pend_reg[7:0];
          nonvolatile_config1_next = pend_reg[7:0];
        end
      end
      volatile_status1_next[flash_reg_pkg::SR1_WEL] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_reg) begin
    if (!rst_reg) begin
      volatile_status1_reg <= flash_reg_pkg::SR1_RESET;
      nonvolatile_status1_reg <= flash_reg_pkg::SR1_RESET;
      volatile_config1_reg <= flash_reg_pkg::CR1_RESET;
      nonvolatile_config1_reg <= flash_reg_pkg::CR1_RESET;
      volatile_config2_reg <= flash_reg_pkg::CR2_RESET;
      pend_reg <= 16'h0000;
      pend_wide_reg <= 1'b0;
      rej_reg <= 1'b0;
    end else begin
      volatile_status1_reg <= volatile_status1_next;
      nonvolatile_status1_reg <= nonvolatile_status1_next;
      volatile_config1_reg <= volatile_config1_next;
      nonvolatile_config1_reg <= nonvolatile_config1_next;
      volatile_config2_reg <= volatile_config2_next;
      pend_reg <= pend_next;
      pend_wide_reg <= pend_wide_next;
      rej_reg <= rej_next;
    end
  end

  assign o_io = io_reg;
  assign o_io_oe = oe_reg;
  assign o_volatile_status1 = volatile_status1_reg;
  assign o_nonvolatile_status1 = nonvolatile_status1_reg;
  assign o_volatile_config1 = volatile_config1_reg;
  assign o_nonvolatile_config1 = nonvolatile_config1_reg;
  assign o_write_rejected = rej_reg;

  // ==========================================================
  // Assertions
  // busy follows start
  AST_WIP_AFTER_START: assert property (@(posedge i_clk) disable iff (!rst_reg)
    wr_start |-> ##2 volatile_status1_reg[flash_reg_pkg::SR1_WIP]) else $error("busy not set");
  AST_WEL_CLEAR: assert property (@(posedge i_clk) disable iff (!rst_reg)
    wr_done |=> !volatile_status1_reg[flash_reg_pkg::SR1_WEL]) else $error("latch not cleared");
  AST_WRITE_NEEDS_WEL: assert property (@(posedge i_clk) disable iff (!rst_reg)
    wr_start |-> volatile_status1_reg[flash_reg_pkg::SR1_WEL]) else $error("write without latch");
  AST_HW_REJECT: assert property (@(posedge i_clk) disable iff (!rst_reg)
    hw_protected |-> !wr_start) else $error("protected write started");
  AST_QUAD_NO_PROT: assert property (@(posedge i_clk) disable iff (!rst_reg)
    (volatile_config1_reg[flash_reg_pkg::CR1_QUAD] && cs_rise && op_reg == flash_reg_pkg::OP_REG_WRITE)
    |=> !o_write_rejected) else $error("quad protected");
  AST_WRITE_ENABLE_CMD_SETS: assert property (@(posedge i_clk) disable iff (!rst_reg)
    (cmd_end_byte && op_reg == flash_reg_pkg::OP_WRITE_ENABLE && !wr_done)
    |=> volatile_status1_reg[flash_reg_pkg::SR1_WEL]) else $error("latch not set");
  AST_WRITE_DISABLE_CMD_BUSY: assert property (@(posedge i_clk) disable iff (!rst_reg)
    (cmd_end_byte && op_reg == flash_reg_pkg::OP_WRITE_DISABLE
     && volatile_status1_reg[flash_reg_pkg::SR1_WIP] && volatile_status1_reg[flash_reg_pkg::SR1_WEL] && !wr_done)
    |=> volatile_status1_reg[flash_reg_pkg::SR1_WEL]) else $error("disable not ignored");
  AST_WRITE_LEN: assert property (@(posedge i_clk) disable iff (!rst_reg)
    wr_start |-> (cnt_reg == unit_len(quad_all, 1'b0) || cnt_reg == unit_len(quad_all, 1'b1)))
    else $error("bad write length");
  AST_OE_OFF: assert property (@(posedge i_clk) disable iff (!rst_reg)
    cs_rise |=> o_io_oe == 4'h0) else $error("output still driven");
  COV_WRITE: cover property (@(posedge i_clk) disable iff (!rst_reg) wr_done);
  COV_READ: cover property (@(posedge i_clk) disable iff (!rst_reg) state_reg == ST_READ);
  COV_REJECT: cover property (@(posedge i_clk) disable iff (!rst_reg) rej_reg);
endmodule : flash_reg_cmd

// ### verif/flash_host_model.sv
// Host memory controller model for the serial flash pins
module flash_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_wire,
  output logic o_cs_n,
  output logic o_sck,
  output logic [3:0] o_io
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_io = 4'h0;
  end
  task automatic half();
    repeat (4) @(posedge i_clk);
    #1;
  endtask : half
  // ==========================================================
  // Frame: opcode, nb write bits, nr read bytes
  // half period of 160 ns
  task automatic xfer(input bit q, input logic [7:0] op, input int nb, input logic [15:0] wd,
      input int nr, output logic [7:0] first, output logic [7:0] last);
    logic [23:0] sh;
    logic [7:0] rb;
    int w;
    int nc;
    sh = {op, wd};
    w = q ? 4 : 1;
    nc = (8 + nb) / w;
    rb = 8'h00;
    first = 8'h00;
    last = 8'h00;
    o_cs_n = 1'b0;
    for (int k = 0; k < nc + nr * 8 / w; k++) begin
      o_sck = 1'b0;
      // MSB first, change while low
      // Idle lines toggle so stale levels never look valid
      o_io = (k < nc) ? (q ? sh[23:20] : {~o_io[3:1], sh[23]}) : ~o_io;
      sh = sh << w;
      half();
      o_sck = 1'b1;
      half();
      // Sampled late in the high phase: device output lags its falling edge
      if (k >= nc) begin
        rb = q ? {rb[3:0], i_wire} : {rb[6:0], i_wire[1]};
        if ((k - nc + 1) % (8 / w) == 0) begin
          if (k - nc + 1 == 8 / w) first = rb;
          last = rb;
        end
      end
    end
    o_sck = 1'b0;
    half();
    o_cs_n = 1'b1;
    o_io = ~o_io;
    half();
    half();
  endtask : xfer
endmodule : flash_host_model

// ### verif/tb_top.sv
// Self-checking bench for the register command interpreter
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] RS1 = flash_reg_pkg::OP_STATUS1_READ;
  localparam logic [7:0] RS2 = flash_reg_pkg::OP_STATUS2_READ;
  localparam logic [7:0] WE = flash_reg_pkg::OP_WRITE_ENABLE;
  localparam logic [7:0] WD = flash_reg_pkg::OP_WRITE_DISABLE;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wp_n = 1'b1;
  logic f_erase = 1'b0;
  logic f_prog = 1'b0;
  logic busy = 1'b0;
  logic qset = 1'b0;
  logic [7:0] st2 = 8'h5a;
  logic cs_n, sck, rej, rej_seen;
  logic [3:0] h_io, d_io, d_oe, wire_io, oe_acc;
  logic [7:0] v1, n1, vc1, nc1, b0, b1;
  int mismatches = 0;
  int checked = 0;
  always #20 clk = ~clk;
  // ==========================================================
  // Wire level and sticky observers
  assign wire_io = (d_oe & d_io) | (~d_oe & h_io);
  always @(posedge clk) begin
    if (rej === 1'b1) rej_seen <= 1'b1;
    oe_acc <= oe_acc | d_oe;
  end
  flash_host_model flash_host_model_i (.i_clk(clk), .i_wire(wire_io), .o_cs_n(cs_n),
    .o_sck(sck), .o_io(h_io));
  flash_reg_cmd flash_reg_cmd_i (.i_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_sck(sck),
    .i_io(wire_io), .i_wp_n(wp_n), .i_op_fail_erase(f_erase), .i_op_fail_prog(f_prog),
    .i_ext_busy(busy), .i_status2(st2), .i_quad_all_set(qset), .o_io(d_io), .o_io_oe(d_oe),
    .o_volatile_status1(v1), .o_nonvolatile_status1(n1), .o_volatile_config1(vc1),
    .o_nonvolatile_config1(nc1), .o_write_rejected(rej));
  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic cmd(input bit q, input logic [7:0] op, input int nb, input logic [15:0] wd,
      input int nr);
    flash_host_model_i.xfer(q, op, nb, wd, nr, b0, b1);
  endtask : cmd
  task automatic rd(input bit q, input logic [7:0] op, input logic [7:0] exp);
    cmd(q, op, 0, 16'h0000, 1);
    chk("read byte", exp, b1);
  endtask : rd
  task automatic wr(input int nb, input logic [15:0] wd);
    cmd(1'b0, WE, 0, 16'h0000, 0);
    cmd(1'b0, flash_reg_pkg::OP_REG_WRITE, nb, wd, 0);
  endtask : wr
  task automatic idle();
    int n;
    step(10);
    for (n = 0; n < 2000 && v1[0] !== 1'b0; n++) step(1);
    chk("busy end", 8'h00, {7'h00, v1[0]});
  endtask : idle
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Watchdog, well past the expected 0.3 ms of traffic
  initial begin
    #3000000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'b1;
    step(10);
    oe_acc = 4'h0;
    rej_seen = 1'b0;
    chk("volatile_status1", 8'h00, v1);
    chk("nonvolatile_status1", 8'h00, n1);
    chk("volatile_config1", 8'h00, vc1);
    chk("nonvolatile_config1", 8'h00, nc1);
    cmd(1'b0, RS1, 0, 16'h0000, 2);
    chk("sr1 first", 8'h00, b0);
    chk("sr1 again", 8'h00, b1);
    chk("serial oe", 8'h02, {4'h0, oe_acc});
    rd(1'b0, RS2, 8'h5a);
    rd(1'b0, flash_reg_pkg::OP_CONFIG_READ, 8'h00);
    done("reads");
    cmd(1'b0, flash_reg_pkg::OP_REG_WRITE, 8, 16'h1c00, 0);
    step(600);
    chk("no latch", 8'h00, v1);
    cmd(1'b0, WE, 0, 16'h0000, 0);
    chk("latch set", 8'h02, v1);
    busy = 1'b1;
    rd(1'b0, RS1, 8'h03);
    cmd(1'b0, WD, 0, 16'h0000, 0);
    rd(1'b0, RS1, 8'h03);
    busy = 1'b0;
    cmd(1'b0, WD, 0, 16'h0000, 0);
    chk("latch clear", 8'h00, v1);
    cmd(1'b0, WE, 8, 16'h0000, 0);
    chk("long enable", 8'h00, v1);
    done("latch");
    wp_n = 1'b0;
    wr(16, 16'h9c08);
    cmd(1'b0, RS1, 0, 16'h0000, 10);
    chk("busy poll", 8'h03, b0 & 8'h03);
    chk("done poll", 8'h9c, b1);
    chk("nonvolatile_status1", 8'h9c, n1);
    chk("volatile_config1", 8'h08, vc1);
    chk("nonvolatile_config1", 8'h08, nc1);
    wr(8, 16'h0000);
    step(600);
    chk("rejected", 8'h9c, v1 & 8'hfc);
    chk("reject pulse", 8'h01, {7'h00, rej_seen});
    wp_n = 1'b1;
    wr(16, 16'h800a);
    idle();
    chk("vol target", 8'h80, v1);
    chk("nv kept", 8'h1c, n1 & 8'h1c);
    chk("volatile_config1 quad", 8'h0a, vc1);
    wp_n = 1'b0;
    wr(8, 16'h8400);
    idle();
    chk("quad unprot", 8'h84, v1);
    wr(12, 16'h0000);
    step(600);
    chk("bad length", 8'h84, v1 & 8'hfd);
    f_erase = 1'b1;
    f_prog = 1'b1;
    wr(8, 16'h9800);
    step(600);
    chk("fail flags", 8'h64, v1 & 8'h7c);
    f_erase = 1'b0;
    f_prog = 1'b0;
    done("write");
    arst_n = 1'b0;
    step(4);
    arst_n = 1'b1;
    step(10);
    chk("reset again", 8'h00, v1);
    qset = 1'b1;
    step(1);
    qset = 1'b0;
    oe_acc = 4'h0;
    rd(1'b1, RS1, 8'h00);
    chk("quad oe", 8'h0f, {4'h0, oe_acc});
    cmd(1'b1, WE, 0, 16'h0000, 0);
    rd(1'b1, RS1, 8'h02);
    oe_acc = 4'h0;
    cmd(1'b1, RS2, 0, 16'h0000, 1);
    chk("quad rd2 off", 8'h00, {4'h0, oe_acc});
    done("quad");
    end_of_test();
  end
endmodule : tb_top
